// ---- cbrd_map.vh ----
`ifndef CBRD_MAP_VH
`define CBRD_MAP_VH
// addressing modes of the read-modify-write group (high nibble)
`define CBRD_HI_ACC        4'h4
`define CBRD_HI_IDX        4'h5
`define CBRD_HI_DIR        4'h3
`define CBRD_HI_IX0        4'h7
`define CBRD_HI_IX1        4'h6
// high nibbles of the two bit groups
`define CBRD_HI_BTB        4'h0
`define CBRD_HI_BSC        4'h1
// read-modify-write operations (low nibble)
`define CBRD_LO_ADD1       4'hC
`define CBRD_LO_SUB1       4'hA
`define CBRD_LO_ZFILL      4'hF
`define CBRD_LO_INV1       4'h3
`define CBRD_LO_INV2       4'h0
`define CBRD_LO_ROL        4'h9
`define CBRD_LO_ROR        4'h6
`define CBRD_LO_SHL        4'h8
`define CBRD_LO_SHR        4'h4
`define CBRD_LO_ASR        4'h7
`define CBRD_LO_TEST       4'hD
// single opcodes
`define CBRD_OP_MUL        8'h42
`define CBRD_OP_TAX        8'h97
`define CBRD_OP_TXA        8'h9F
`define CBRD_OP_SECF       8'h99
`define CBRD_OP_CLCF       8'h98
`define CBRD_OP_SEIM       8'h9B
`define CBRD_OP_CLIM       8'h9A
`define CBRD_OP_SPRL       8'h9C
`define CBRD_OP_IDLE       8'h9D
`define CBRD_OP_TRAP       8'h83
`define CBRD_OP_SUBRET     8'h81
`define CBRD_OP_TRAPRET    8'h80
`define CBRD_OP_HALT       8'h8E
`define CBRD_OP_WAITI      8'h8F
// cycle counts
`define CBRD_CYC_BTB       4'h5
`define CBRD_CYC_BSC       4'h5
`define CBRD_CYC_INH_RMW   4'h3
`define CBRD_CYC_DIR_RMW   4'h5
`define CBRD_CYC_IX0_RMW   4'h5
`define CBRD_CYC_IX1_RMW   4'h6
`define CBRD_CYC_MUL       4'hB
`define CBRD_CYC_CTRL      4'h2
`define CBRD_CYC_TRAP      4'hA
`define CBRD_CYC_SUBRET    4'h6
`define CBRD_CYC_TRAPRET   4'h9
// operation classes
`define CBRD_CL_NONE       5'h00
`define CBRD_CL_BR_ONE     5'h01
`define CBRD_CL_BR_ZERO    5'h02
`define CBRD_CL_FORCE_ONE  5'h03
`define CBRD_CL_FORCE_ZERO 5'h04
`define CBRD_CL_ADD1       5'h05
`define CBRD_CL_SUB1       5'h06
`define CBRD_CL_ZFILL      5'h07
`define CBRD_CL_INV1       5'h08
`define CBRD_CL_INV2       5'h09
`define CBRD_CL_ROL        5'h0A
`define CBRD_CL_ROR        5'h0B
`define CBRD_CL_SHL        5'h0C
`define CBRD_CL_SHR        5'h0D
`define CBRD_CL_ASR        5'h0E
`define CBRD_CL_TEST       5'h0F
`define CBRD_CL_MUL        5'h10
`define CBRD_CL_TAX        5'h11
`define CBRD_CL_TXA        5'h12
`define CBRD_CL_SECF       5'h13
`define CBRD_CL_CLCF       5'h14
`define CBRD_CL_SEIM       5'h15
`define CBRD_CL_CLIM       5'h16
`define CBRD_CL_SPRL       5'h17
`define CBRD_CL_IDLE       5'h18
`define CBRD_CL_TRAP       5'h19
`define CBRD_CL_SUBRET     5'h1A
`define CBRD_CL_TRAPRET    5'h1B
`define CBRD_CL_HALT       5'h1C
`define CBRD_CL_WAITI      5'h1D
// addressing mode codes
`define CBRD_AM_INH        3'h0
`define CBRD_AM_DIR        3'h1
`define CBRD_AM_IX0        3'h2
`define CBRD_AM_IX1        3'h3
`define CBRD_AM_BTB        3'h4
`define CBRD_AM_BSC        3'h5
`endif

// ---- cbrd_rmw_dec.v ----
`timescale 1ns/100ps
`include "cbrd_map.vh"
module cbrd_rmw_dec (
   input  wire [7:0] opcode,
   output reg        hit,
   output reg  [4:0] op_class,
   output reg  [2:0] addr_mode,
   output reg  [1:0] length,
   output reg  [3:0] cycles,
   output reg        write_back,
   output reg        src_x
);
   always @* begin
      hit        = 1'b1;
      op_class   = `CBRD_CL_NONE;
      addr_mode  = `CBRD_AM_INH;
      length     = 2'd1;
      cycles     = `CBRD_CYC_INH_RMW;
      write_back = 1'b1;
      src_x      = 1'b0;
      case (opcode[3:0])
         `CBRD_LO_ROL:   op_class = `CBRD_CL_ROL;   // [RQ5]
         `CBRD_LO_ROR:   op_class = `CBRD_CL_ROR;   // [RQ6]
         `CBRD_LO_ADD1:  op_class = `CBRD_CL_ADD1;  // [RQ10]
         `CBRD_LO_SUB1:  op_class = `CBRD_CL_SUB1;  // [RQ10]
         `CBRD_LO_ZFILL: op_class = `CBRD_CL_ZFILL; // [RQ10]
         `CBRD_LO_INV1:  op_class = `CBRD_CL_INV1;  // [RQ10]
         `CBRD_LO_INV2:  op_class = `CBRD_CL_INV2;  // [RQ10]
         `CBRD_LO_SHL:   op_class = `CBRD_CL_SHL;   // [RQ10]
         `CBRD_LO_SHR:   op_class = `CBRD_CL_SHR;   // [RQ10]
         `CBRD_LO_ASR:   op_class = `CBRD_CL_ASR;   // [RQ10]
         `CBRD_LO_TEST: begin
            op_class   = `CBRD_CL_TEST;
            write_back = 1'b0; // [RQ7]
         end
         default:        hit = 1'b0;
      endcase
      case (opcode[7:4]) // [RQ4]
         `CBRD_HI_ACC: ;
         `CBRD_HI_IDX:  src_x = 1'b1;
         `CBRD_HI_DIR: begin
            addr_mode = `CBRD_AM_DIR;
            length    = 2'd2;
            cycles    = `CBRD_CYC_DIR_RMW;
         end
         `CBRD_HI_IX0: begin
            addr_mode = `CBRD_AM_IX0;
            cycles    = `CBRD_CYC_IX0_RMW;
         end
         `CBRD_HI_IX1: begin
            addr_mode = `CBRD_AM_IX1;
            length    = 2'd2;
            cycles    = `CBRD_CYC_IX1_RMW;
         end
         default:       hit = 1'b0;
      endcase
      // no write-back cycle for the test on memory
      if (!write_back && addr_mode != `CBRD_AM_INH)
         cycles = cycles - 4'd1; // [RQ7]
      if (!write_back)
         write_back = 1'b0;
      else if (addr_mode == `CBRD_AM_INH)
         write_back = 1'b0;
   end
endmodule // cbrd_rmw_dec

// ---- cbrd_decode.v ----
`timescale 1ns/100ps
`include "cbrd_map.vh"
// Overview of operation
// [RQ1] opcodes 2n: three bytes, branch if direct-page bit n is one, five cycles
// [RQ2] opcodes 2n+1: three bytes, branch if direct-page bit n is zero, five cycles
// [RQ3] 0x10+2n forces bit n one, 0x11+2n forces zero; two bytes, five cycles
// [RQ4] high nibble picks mode: 4 A, 5 X, 3 dir, 7 ix, 6 ix8; 3,3,5,5,6 cycles
// [RQ5] low nibble 9 rotates left through carry, in all five modes
// [RQ6] low nibble 6 rotates right through carry, in all five modes
// [RQ7] sign-zero test has no write-back: 4 dir, 4 ix, 5 ix8 cycles
// [RQ8] 0x9B sets interrupt mask, one byte, two cycles
// [RQ9] 0x9A clears interrupt mask, one byte, two cycles
// [RQ10] other nibbles: inc, dec, clear, invert, negate, shifts; 0x42 multiply 11 cycles
// [RQ11] control opcodes: transfers, carry, stack, idle 2; trap 10, return 6, 9; stop, wait
module cbrd_decode (
   mclk,
   rstn,
   op_valid,
   opcode,
   dec_valid_q,
   dec_known_q,
   op_class_q,
   addr_mode_q,
   bit_index_q,
   length_q,
   cycles_q,
   write_back_q,
   src_x_q,
   branch_on_one_q
);
   input  wire       mclk;
   input  wire       rstn;
   input  wire       op_valid;
   input  wire [7:0] opcode;
   output reg        dec_valid_q;
   output reg        dec_known_q;
   output reg  [4:0] op_class_q;
   output reg  [2:0] addr_mode_q;
   output reg  [2:0] bit_index_q;
   output reg  [1:0] length_q;
   output reg  [3:0] cycles_q;
   output reg        write_back_q;
   output reg        src_x_q;
   output reg        branch_on_one_q;

   wire       rmw_hit;
   wire [4:0] rmw_class;
   wire [2:0] rmw_mode;
   wire [1:0] rmw_len;
   wire [3:0] rmw_cyc;
   wire       rmw_wb;
   wire       rmw_x;

   reg        known_d;
   reg  [4:0] class_d;
   reg  [2:0] mode_d;
   reg  [1:0] len_d;
   reg  [3:0] cyc_d;
   reg        wb_d;
   reg        x_d;
   reg        one_d;

   cbrd_rmw_dec cbrd_rmw_dec_inst (
      .opcode     (opcode),
      .hit        (rmw_hit),
      .op_class   (rmw_class),
      .addr_mode  (rmw_mode),
      .length     (rmw_len),
      .cycles     (rmw_cyc),
      .write_back (rmw_wb),
      .src_x      (rmw_x)
   );

   // inherent single-byte control group; unknown returns zero cycles
   function [8:0] ctrl_dec;
      input [7:0] op;
      begin
         case (op)
            `CBRD_OP_TAX:     ctrl_dec = {`CBRD_CL_TAX,     `CBRD_CYC_CTRL};    // [RQ11]
            `CBRD_OP_TXA:     ctrl_dec = {`CBRD_CL_TXA,     `CBRD_CYC_CTRL};    // [RQ11]
            `CBRD_OP_SECF:    ctrl_dec = {`CBRD_CL_SECF,    `CBRD_CYC_CTRL};    // [RQ11]
            `CBRD_OP_CLCF:    ctrl_dec = {`CBRD_CL_CLCF,    `CBRD_CYC_CTRL};    // [RQ11]
            `CBRD_OP_SEIM:    ctrl_dec = {`CBRD_CL_SEIM,    `CBRD_CYC_CTRL};    // [RQ8]
            `CBRD_OP_CLIM:    ctrl_dec = {`CBRD_CL_CLIM,    `CBRD_CYC_CTRL};    // [RQ9]
            `CBRD_OP_SPRL:    ctrl_dec = {`CBRD_CL_SPRL,    `CBRD_CYC_CTRL};    // [RQ11]
            `CBRD_OP_IDLE:    ctrl_dec = {`CBRD_CL_IDLE,    `CBRD_CYC_CTRL};    // [RQ11]
            `CBRD_OP_TRAP:    ctrl_dec = {`CBRD_CL_TRAP,    `CBRD_CYC_TRAP};    // [RQ11]
            `CBRD_OP_SUBRET:  ctrl_dec = {`CBRD_CL_SUBRET,  `CBRD_CYC_SUBRET};  // [RQ11]
            `CBRD_OP_TRAPRET: ctrl_dec = {`CBRD_CL_TRAPRET, `CBRD_CYC_TRAPRET}; // [RQ11]
            `CBRD_OP_HALT:    ctrl_dec = {`CBRD_CL_HALT,    `CBRD_CYC_CTRL};    // [RQ11]
            `CBRD_OP_WAITI:   ctrl_dec = {`CBRD_CL_WAITI,   `CBRD_CYC_CTRL};    // [RQ11]
            `CBRD_OP_MUL:     ctrl_dec = {`CBRD_CL_MUL,     `CBRD_CYC_MUL};     // [RQ10]
            default:          ctrl_dec = {`CBRD_CL_NONE,    4'h0};
         endcase
      end
   endfunction

   // one select line per bit index, shared by both bit groups
   function [7:0] idx_onehot;
      input [2:0] idx;
      begin
         idx_onehot      = 8'h00;
         idx_onehot[idx] = 1'b1;
      end
   endfunction

   // high-nibble group test, used for both bit groups
   function grp_is;
      input [7:0] op;
      input [3:0] hi;
      begin
         grp_is = (op[7:4] == hi);
      end
   endfunction

   wire [8:0] ctrl_v;
   wire       ctrl_hit;
   wire       rmw_sel;
   wire [7:0] idx_sel;
   wire       btb_grp;
   wire       bsc_grp;
   wire [7:0] btb_one_hit;
   wire [7:0] btb_zero_hit;
   wire [7:0] bsc_one_hit;
   wire [7:0] bsc_zero_hit;
   genvar     n;

   assign ctrl_v   = ctrl_dec(opcode);
   assign ctrl_hit = (ctrl_v[8:4] != `CBRD_CL_NONE);
   // control and multiply codes outrank the read-modify-write table
   assign rmw_sel  = rmw_hit && !ctrl_hit;
   assign idx_sel  = idx_onehot(opcode[3:1]);
   assign btb_grp  = grp_is(opcode, `CBRD_HI_BTB);
   assign bsc_grp  = grp_is(opcode, `CBRD_HI_BSC);

   generate
      for (n = 0; n < 8; n = n + 1) begin : g_bit
         assign btb_one_hit[n]  = btb_grp && !opcode[0] && idx_sel[n]; // [RQ1]
         assign btb_zero_hit[n] = btb_grp && opcode[0] && idx_sel[n];  // [RQ2]
         assign bsc_one_hit[n]  = bsc_grp && !opcode[0] && idx_sel[n]; // [RQ3]
         assign bsc_zero_hit[n] = bsc_grp && opcode[0] && idx_sel[n];  // [RQ3]
      end
   endgenerate

   always @* begin
      known_d = 1'b0;
      class_d = `CBRD_CL_NONE;
      mode_d  = `CBRD_AM_INH;
      len_d   = 2'd1;
      cyc_d   = 4'h0;
      wb_d    = 1'b0;
      x_d     = 1'b0;
      one_d   = 1'b0;
      if ((|btb_one_hit) || (|btb_zero_hit)) begin
         known_d = 1'b1;
         mode_d  = `CBRD_AM_BTB;
         len_d   = 2'd3;
         cyc_d   = `CBRD_CYC_BTB;
         if (|btb_one_hit) begin
            class_d = `CBRD_CL_BR_ONE;  // [RQ1]
            one_d   = 1'b1;             // [RQ1]
         end else begin
            class_d = `CBRD_CL_BR_ZERO; // [RQ2]
         end
      end else if ((|bsc_one_hit) || (|bsc_zero_hit)) begin
         known_d = 1'b1;
         mode_d  = `CBRD_AM_BSC;
         len_d   = 2'd2;
         cyc_d   = `CBRD_CYC_BSC;       // [RQ3]
         wb_d    = 1'b1;
         class_d = (|bsc_zero_hit) ? `CBRD_CL_FORCE_ZERO : `CBRD_CL_FORCE_ONE; // [RQ3]
      end else if (ctrl_hit) begin
         known_d = 1'b1;
         class_d = ctrl_v[8:4];
         cyc_d   = ctrl_v[3:0];
      end else if (rmw_sel) begin
         known_d = 1'b1;
         class_d = rmw_class;           // [RQ4]
         mode_d  = rmw_mode;
         len_d   = rmw_len;
         cyc_d   = rmw_cyc;
         wb_d    = rmw_wb;
         x_d     = rmw_x;
      end
   end

   // valid mirrors every strobe, known or not, so the core can count fetches
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         dec_valid_q <= 1'b0;
      end else begin
         dec_valid_q <= op_valid;
      end
   end

   // fields hold until the next strobe; a gap on the bus never clears them
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         dec_known_q  <= 1'b0;
         op_class_q   <= `CBRD_CL_NONE;
         addr_mode_q  <= `CBRD_AM_INH;
         length_q     <= 2'd0;
         cycles_q     <= 4'h0;
         write_back_q <= 1'b0;
         src_x_q      <= 1'b0;
      end else if (op_valid) begin
         dec_known_q  <= known_d;
         op_class_q   <= class_d;
         addr_mode_q  <= mode_d;
         length_q     <= len_d;
         cycles_q     <= cyc_d;
         write_back_q <= wb_d;
         src_x_q      <= x_d;
      end
   end

   // bit-group fields; the index is taken for every opcode, the core ignores it elsewhere
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         bit_index_q     <= 3'd0;
         branch_on_one_q <= 1'b0;
      end else if (op_valid) begin
         bit_index_q     <= opcode[3:1]; // [RQ1]
         branch_on_one_q <= one_d;
      end
   end
endmodule // cbrd_decode

// ---- cbrd_properties.sv ----
`timescale 1ns/100ps
`include "cbrd_map.vh"
module cbrd_properties (
   input wire logic       mclk,
   input wire logic       rstn,
   input wire logic       op_valid,
   input wire logic [7:0] opcode,
   input wire logic [4:0] op_class_q,
   input wire logic [2:0] bit_index_q,
   input wire logic [1:0] length_q,
   input wire logic [3:0] cycles_q,
   input wire logic       write_back_q
);
   wire [3:0] hi  = opcode[7:4];
   wire [3:0] cyc = (hi == 4'h4 || hi == 4'h5) ? 4'h3 : (hi == 4'h6) ? 4'h6 : 4'h5;
   wire       mem = hi == 4'h3 || hi == 4'h6 || hi == 4'h7;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   sequence taken(c);
      op_valid && c;
   endsequence
   br_one_a: assert property (taken(hi == 4'h0 && !opcode[0])
      |=> op_class_q == `CBRD_CL_BR_ONE && length_q == 2'h3 && cycles_q == 4'h5
      && bit_index_q == $past(opcode[3:1])) else $error("branch on one decode wrong");
   br_zero_a: assert property (taken(hi == 4'h0 && opcode[0])
      |=> op_class_q == `CBRD_CL_BR_ZERO && length_q == 2'h3 && cycles_q == 4'h5)
      else $error("branch on zero decode wrong");
   bit_force_a: assert property (taken(hi == 4'h1)
      |=> length_q == 2'h2 && cycles_q == 4'h5 && bit_index_q == $past(opcode[3:1])
      && op_class_q == ($past(opcode[0]) ? `CBRD_CL_FORCE_ZERO : `CBRD_CL_FORCE_ONE))
      else $error("bit force decode wrong");
   rmw_cycles_a: assert property (taken(hi >= 4'h3 && hi <= 4'h7 && opcode[3:0] == 4'hC)
      |=> cycles_q == $past(cyc)) else $error("read-modify-write cycles wrong");
   rot_left_a: assert property (taken(hi >= 4'h3 && hi <= 4'h7 && opcode[3:0] == 4'h9)
      |=> op_class_q == `CBRD_CL_ROL) else $error("rotate left decode wrong");
   rot_right_a: assert property (taken(hi >= 4'h3 && hi <= 4'h7 && opcode[3:0] == 4'h6)
      |=> op_class_q == `CBRD_CL_ROR) else $error("rotate right decode wrong");
   test_nowb_a: assert property (taken(mem && opcode[3:0] == 4'hD) |=> !write_back_q
      && cycles_q == $past(cyc) - 4'h1) else $error("sign zero test decode wrong");
   mask_ops_a: assert property (taken(opcode[7:1] == 7'h4D) |=> length_q == 2'h1
      && cycles_q == 4'h2 && op_class_q == ($past(opcode[0]) ? `CBRD_CL_SEIM : `CBRD_CL_CLIM))
      else $error("mask opcode decode wrong");
   mul_decode_a: assert property (taken(opcode == 8'h42)
      |=> op_class_q == `CBRD_CL_MUL && cycles_q == 4'hB && length_q == 2'h1)
      else $error("multiply decode wrong");
endmodule // cbrd_properties
bind cbrd_decode cbrd_properties cbrd_properties_inst (.mclk(mclk), .rstn(rstn),
   .op_valid(op_valid), .opcode(opcode), .op_class_q(op_class_q), .bit_index_q(bit_index_q),
   .length_q(length_q), .cycles_q(cycles_q), .write_back_q(write_back_q));

// ---- cbrd_opmem.sv ----
`timescale 1ns/100ps
// program memory: byte at address a is a; answers one edge after the fetch
module cbrd_opmem (
   input  wire logic       mclk,
   input  wire logic       fetch,
   input  wire logic [7:0] addr,
   output logic            op_valid,
   output logic [7:0]      opcode
);
   initial begin
      op_valid = 1'b0;
      opcode   = 8'h00;
   end
   // an idle bus inverts its byte on every edge, so the last byte alternates with its inverse
   always @(posedge mclk) begin
      op_valid <= fetch;
      opcode   <= fetch ? addr : ~opcode;
   end
endmodule // cbrd_opmem

// ---- cbrd_decode_test.sv ----
`timescale 1ns/100ps
module cbrd_decode_test;
   logic       mclk = 1'b0, rstn = 1'b0, fetch = 1'b0, op_valid, dv, kn, wb, sx, b1;
   logic [7:0] addr = 8'h00, opcode;
   logic [4:0] cl;
   logic [2:0] am, bi;
   logic [1:0] ln;
   logic [3:0] cy;
   int         err_total = 0, comparisons = 0;
   cbrd_opmem cbrd_opmem_inst (.mclk(mclk), .fetch(fetch), .addr(addr), .op_valid(op_valid),
      .opcode(opcode));
   cbrd_decode cbrd_decode_inst (.mclk(mclk), .rstn(rstn), .op_valid(op_valid), .opcode(opcode),
      .dec_valid_q(dv), .dec_known_q(kn), .op_class_q(cl), .addr_mode_q(am), .bit_index_q(bi),
      .length_q(ln), .cycles_q(cy), .write_back_q(wb), .src_x_q(sx), .branch_on_one_q(b1));
   wire [15:0] summ = {kn, cl, am, ln, cy, b1};
   initial forever #2 mclk = ~mclk;
   task automatic chk(input [15:0] got, input [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // fetch one byte; results are looked at mid-cycle once the decode has landed
   task automatic dec(input [7:0] a);
      @(posedge mclk) begin fetch <= 1'b1; addr <= a; end
      @(posedge mclk) fetch <= 1'b0;
      @(negedge mclk);
      @(negedge mclk);
      chk({15'h0, dv}, 16'h0001);
   endtask
   task automatic t_bits;
      for (int n = 0; n < 8; n++) begin
         dec(8'(2 * n));
         chk(summ, {1'b1, 5'h01, 3'h4, 2'h3, 4'h5, 1'b1});
         chk({13'h0, bi}, 16'(n));
         dec(8'(2 * n + 1));
         chk(summ, {1'b1, 5'h02, 3'h4, 2'h3, 4'h5, 1'b0});
         dec(8'(8'h10 + 2 * n));
         chk(summ, {1'b1, 5'h03, 3'h5, 2'h2, 4'h5, 1'b0});
         dec(8'(8'h11 + 2 * n));
         chk(summ, {1'b1, 5'h04, 3'h5, 2'h2, 4'h5, 1'b0});
         chk({13'h0, bi}, 16'(n));
      end
      $display("test bits done");
   endtask
   task automatic t_rmw;
      logic [3:0] lo[11] = '{4'hC, 4'hA, 4'hF, 4'h3, 4'h0, 4'h9, 4'h6, 4'h8, 4'h4, 4'h7, 4'hD};
      logic [3:0] hi[5] = '{4'h4, 4'h5, 4'h3, 4'h7, 4'h6};
      logic [3:0] cyc[5] = '{4'h3, 4'h3, 4'h5, 4'h5, 4'h6};
      logic [2:0] md[5] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3};
      logic [1:0] len[5] = '{2'h1, 2'h1, 2'h2, 2'h1, 2'h2};
      for (int i = 0; i < 11; i++)
         for (int m = 0; m < 5; m++) begin
            dec({hi[m], lo[i]});
            chk(summ, {1'b1, 5'(5 + i), md[m], len[m],
               cyc[m] - ((i == 10 && m > 1) ? 4'h1 : 4'h0), 1'b0});
            chk({14'h0, wb, sx}, {14'h0, m > 1 && i != 10, m == 1});
         end
      $display("test rmw done");
   endtask
   task automatic t_ctrl;
      logic [7:0] op[15] = '{8'h97, 8'h9F, 8'h99, 8'h98, 8'h9B, 8'h9A, 8'h9C, 8'h9D, 8'h83,
         8'h81, 8'h80, 8'h8E, 8'h8F, 8'h42, 8'hA6};
      logic [3:0] cyc[15] = '{4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'hA, 4'h6,
         4'h9, 4'h2, 4'h2, 4'hB, 4'h0};
      logic [4:0] c[15] = '{5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19,
         5'h1A, 5'h1B, 5'h1C, 5'h1D, 5'h10, 5'h00};
      // the last entry is outside the covered groups and must decode as unknown
      for (int i = 0; i < 15; i++) begin
         dec(op[i]);
         chk(summ, {i != 14, c[i], 3'h0, 2'h1, cyc[i], 1'b0});
      end
      $display("test ctrl done");
   endtask
   // two strobes back to back; each result lands one edge after its own byte
   task automatic t_back;
      @(posedge mclk) begin fetch <= 1'b1; addr <= 8'h3D; end
      @(posedge mclk) addr <= 8'h9B;
      @(posedge mclk) fetch <= 1'b0;
      @(negedge mclk);
      chk(summ, {1'b1, 5'h0F, 3'h1, 2'h2, 4'h4, 1'b0});
      chk({14'h0, wb, sx}, 16'h0000);
      @(negedge mclk);
      chk(summ, {1'b1, 5'h15, 3'h0, 2'h1, 4'h2, 1'b0});
      $display("test back to back done");
   endtask
   // reset mid-run clears every field, and decoding resumes with no stale state
   task automatic t_reset;
      dec(8'h1E);
      chk(summ, {1'b1, 5'h03, 3'h5, 2'h2, 4'h5, 1'b0});
      chk({13'h0, bi}, 16'h0007);
      @(posedge mclk) rstn <= 1'b0;
      @(negedge mclk);
      chk(summ, 16'h0000);
      chk({10'h0, dv, bi, wb, sx}, 16'h0000);
      @(posedge mclk) rstn <= 1'b1;
      dec(8'h07);
      chk(summ, {1'b1, 5'h02, 3'h4, 2'h3, 4'h5, 1'b0});
      chk({13'h0, bi}, 16'h0003);
      $display("test reset done");
   endtask
   task automatic give_verdict;
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      t_bits;
      t_rmw;
      t_ctrl;
      t_back;
      t_reset;
      give_verdict;
   end
   initial begin
      #(4 * 20000);
      err_total++;
      give_verdict;
   end
endmodule // cbrd_decode_test
